/* core/dalc_pkg.sv */
// Constants for the activity indicator controller.
// Assumes a 40 MHz core clock.
package dalc_pkg;

  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned BLINK_HALF_MS    = 500;
  localparam int unsigned BLINK_HALF_CYC   = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam logic        POLARITY_RST     = 1'b0;
  localparam logic        LIT_RST          = 1'b0;
  localparam logic        BLINK_LIT_RST    = 1'b1;

  typedef enum logic [1:0] {
    DALC_SPUN_DOWN,
    DALC_SPUN_UP,
    DALC_TRANSITION
  } dalc_spin_t;

endpackage : dalc_pkg

/* core/dalc_led.sv */
// Drive activity indicator controller with open-collector output.
// Assumes spindle, activity and format inputs come from other clock domains.
//
// Functional notes
// - Spun down, idle: indicator unlit regardless of polarity select.
// - Spun down, command executing: indicator lit regardless of polarity.
// - Spun up, idle: lit when select is 0, unlit when 1.
// - Spun up, executing: unlit when select is 0, lit when 1.
// - Spinning up or down: blink half second lit, half second unlit.
// - Format running: invert indicator at each cylinder change.
// - Lit pulls output low; unlit releases output to high impedance.
`timescale 1ns/100ps
module dalc_led
  import dalc_pkg::*;
#(
  parameter int unsigned BLINK_HALF = BLINK_HALF_CYC
)
(
  input  wire logic mclk,
  input  wire logic sys_rst,
  input  wire logic spindle_at_speed,
  input  wire logic spindle_moving,
  input  wire logic cmd_active,
  input  wire logic format_active,
  input  wire logic cylinder_step,
  input  wire logic indicator_polarity_select,
  output logic      activity_indicator_out,
  output logic      activity_indicator_oe
);

  localparam int CW = $clog2(BLINK_HALF + 1);

  // Half period must fit the counter and an int
  if (BLINK_HALF == 32'h0 || BLINK_HALF > 32'h7FFFFFFF)
  begin : g_bad_half
    $error("BLINK_HALF out of range");
  end

  typedef struct packed {
    logic [1:0]    at_speed_s;
    logic [1:0]    moving_s;
    logic [1:0]    cmd_s;
    logic [1:0]    fmt_s;
    logic [1:0]    step_s;
    logic [1:0]    pol_s;
    logic          step_d;
    logic          fmt_d;
    logic [CW-1:0] blink_cnt;
    logic          blink_lit;
    logic          fmt_lit;
    logic          lit;
  } dalc_state_t;

  dalc_state_t st_reg;
  dalc_state_t st_next;
  dalc_spin_t  spin;
  logic        steady_lit;
  logic        step_rise;
  logic        fmt_rise;

  ////////////////////////////////////////////////////////////////////////////
  // Spindle decode
  function automatic dalc_spin_t dalc_spin_decode(logic at_spd, logic mov);
    if (mov)
      return DALC_TRANSITION;
    else if (at_spd)
      return DALC_SPUN_UP;
    else
      return DALC_SPUN_DOWN;
  endfunction : dalc_spin_decode

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    st_next   = st_reg;
    spin      = dalc_spin_decode(st_reg.at_speed_s[1], st_reg.moving_s[1]);
    step_rise = st_reg.step_s[1] && !st_reg.step_d;
    fmt_rise  = st_reg.fmt_s[1] && !st_reg.fmt_d;

    // Only stage two of each synchroniser feeds logic
    st_next.at_speed_s = {st_reg.at_speed_s[0], spindle_at_speed};
    st_next.moving_s   = {st_reg.moving_s[0], spindle_moving};
    st_next.cmd_s      = {st_reg.cmd_s[0], cmd_active};
    st_next.fmt_s      = {st_reg.fmt_s[0], format_active};
    st_next.step_s     = {st_reg.step_s[0], cylinder_step};
    st_next.pol_s      = {st_reg.pol_s[0], indicator_polarity_select};
    st_next.step_d     = st_reg.step_s[1];
    st_next.fmt_d      = st_reg.fmt_s[1];

    // Steady indicator from spindle and activity
    steady_lit = 1'b0;
    unique case (spin)
      DALC_SPUN_DOWN:
        steady_lit = st_reg.cmd_s[1];
      DALC_SPUN_UP:
        steady_lit = st_reg.cmd_s[1] ~^ st_reg.pol_s[1];
      DALC_TRANSITION:
        steady_lit = st_reg.blink_lit;
    endcase

    // Blink timer runs only while spinning up or down
    if (spin != DALC_TRANSITION)
    begin
      st_next.blink_cnt = '0;
      st_next.blink_lit = BLINK_LIT_RST;
    end
    else if (st_reg.blink_cnt == CW'(BLINK_HALF - 1))
    begin
      st_next.blink_cnt = '0;
      st_next.blink_lit = ~st_reg.blink_lit;
    end
    else
      st_next.blink_cnt = st_reg.blink_cnt + CW'(1);

    // Format toggle starts from the current indicator state
    if (st_reg.fmt_s[1] && !st_reg.fmt_d)
      st_next.fmt_lit = st_reg.lit;
    else if (st_reg.fmt_s[1] && st_reg.step_s[1] && !st_reg.step_d)
      st_next.fmt_lit = ~st_reg.fmt_lit;

    if (st_reg.fmt_s[1])
      st_next.lit = st_next.fmt_lit;
    else
      st_next.lit = steady_lit;

    if (sys_rst)
    begin
      st_next           = '0;
      st_next.lit       = LIT_RST;
      st_next.pol_s     = {2{POLARITY_RST}};
      st_next.blink_lit = BLINK_LIT_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk)
    st_reg <= st_next;

  ////////////////////////////////////////////////////////////////////////////
  // Open collector: drive low only when lit
  assign activity_indicator_out = 1'b0;
  assign activity_indicator_oe  = st_reg.lit;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_down_idle_off: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!st_reg.fmt_s[1] && spin == DALC_SPUN_DOWN && !st_reg.cmd_s[1])
      |=> !activity_indicator_oe)
    else $error("indicator lit while spun down and idle");

  chk_down_busy_on: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!st_reg.fmt_s[1] && spin == DALC_SPUN_DOWN && st_reg.cmd_s[1])
      |=> activity_indicator_oe)
    else $error("indicator unlit while spun down and busy");

  chk_up_idle_pol: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!st_reg.fmt_s[1] && spin == DALC_SPUN_UP && !st_reg.cmd_s[1])
      |=> activity_indicator_oe == !$past(st_reg.pol_s[1]))
    else $error("spun-up idle state wrong for polarity");

  chk_up_busy_pol: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!st_reg.fmt_s[1] && spin == DALC_SPUN_UP && st_reg.cmd_s[1])
      |=> activity_indicator_oe == $past(st_reg.pol_s[1]))
    else $error("spun-up busy state wrong for polarity");

  chk_blink_period: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (spin == DALC_TRANSITION && st_reg.blink_cnt == CW'(BLINK_HALF - 1))
      |=> st_reg.blink_lit != $past(st_reg.blink_lit))
    else $error("blink did not flip at half period");

  chk_blink_follow: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (!st_reg.fmt_s[1] && spin == DALC_TRANSITION)
      |=> activity_indicator_oe == $past(st_reg.blink_lit))
    else $error("indicator not following blink while spinning");

  chk_blink_cnt_range: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st_reg.blink_cnt < CW'(BLINK_HALF))
    else $error("blink counter beyond half period");

  chk_fmt_toggle: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (st_reg.fmt_s[1] && st_reg.fmt_d && step_rise)
      |=> activity_indicator_oe != $past(activity_indicator_oe))
    else $error("format step did not toggle indicator");

  chk_fmt_start_hold: assert property (
    @(posedge mclk) disable iff (sys_rst)
    fmt_rise |=> $stable(activity_indicator_oe))
    else $error("format start changed indicator state");

  chk_oc_low: assert property (
    @(posedge mclk) disable iff (sys_rst)
    activity_indicator_oe |-> activity_indicator_out == 1'b0)
    else $error("indicator driven high");

  chk_fmt_prio: assert property (
    @(posedge mclk) disable iff (sys_rst)
    (st_reg.fmt_s[1] && st_reg.fmt_d && !step_rise)
      |=> $stable(activity_indicator_oe))
    else $error("steady state overrode format toggle");

  chk_fmt_over_steady: assert property (
    @(posedge mclk) disable iff (sys_rst)
    st_reg.fmt_s[1] |=> activity_indicator_oe == st_reg.fmt_lit)
    else $error("indicator not showing format toggle state");

endmodule : dalc_led

/* dv/dalc_lamp.sv */
// External lamp model on the open-collector indicator line.
// Assumes a pull-up: a released line sits high, lamp dark.
`timescale 1ns/100ps
module dalc_lamp
(
  input  wire logic oc_data,
  input  wire logic oc_oe,
  output logic      lamp_lit
);
  wire logic line_lvl;
  assign line_lvl = oc_oe ? oc_data : 1'b1;
  assign lamp_lit = ~line_lvl;
endmodule : dalc_lamp

/* dv/tb_top.sv */
// Scenario bench for the activity indicator controller.
// Assumes the lamp model; blink half period shortened to 4 cycles.
`timescale 1ns/100ps
module tb_top;
  import dalc_pkg::*;
  logic      mclk = 1'b0;
  logic      sys_rst = 1'b1;
  logic      at = 1'b0;
  logic      mov = 1'b0;
  logic      cmd = 1'b0;
  logic      fmt = 1'b0;
  logic      step = 1'b0;
  logic      pol = 1'b0;
  wire logic oc_d;
  wire logic oc_oe;
  wire logic lit;
  int        n_mismatch = 0;
  int        check_count = 0;
  dalc_led #(.BLINK_HALF(4)) i_dut (.mclk(mclk), .sys_rst(sys_rst),
    .spindle_at_speed(at), .spindle_moving(mov), .cmd_active(cmd),
    .format_active(fmt), .cylinder_step(step),
    .indicator_polarity_select(pol), .activity_indicator_out(oc_d),
    .activity_indicator_oe(oc_oe));
  dalc_lamp i_lamp (.oc_data(oc_d), .oc_oe(oc_oe), .lamp_lit(lit));
  initial forever #12.5 mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task cmp(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task cmp_n(input int got, input int exp);
    check_count++;
    if (got != exp)
    begin
      n_mismatch++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_n
  task wt(input int n);
    repeat (n) @(negedge mclk);
  endtask : wt
  ////////////////////////////////////////////////////////////////////////
  task t_steady;
    for (int i = 0; i < 8; i++)
    begin
      {at, cmd, pol} = i[2:0];
      wt(6);
      cmp(lit, at ? ~(cmd ^ pol) : cmd);
      cmp(oc_d, 1'b0);
    end
    $display("Steady states done");
  endtask : t_steady
  task t_blink;
    int on_cnt;
    int flips;
    logic prev;
    on_cnt = 0;
    flips = 0;
    {at, cmd, mov} = 3'h3;
    wt(6);
    prev = lit;
    repeat (32)
    begin
      wt(1);
      on_cnt += (lit === 1'b1);
      flips += (lit !== prev);
      prev = lit;
    end
    cmp_n(on_cnt, 16);
    cmp_n(flips, 8);
    mov = 1'b0;
    $display("Blink done");
  endtask : t_blink
  task t_format;
    {at, cmd, pol} = 3'h4;
    wt(6);
    fmt = 1'b1;
    wt(6);
    cmp(lit, 1'b1);
    cmd = 1'b1;
    wt(6);
    cmp(lit, 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      step = 1'b1;
      wt(2);
      step = 1'b0;
      wt(6);
      cmp(lit, k[0]);
    end
    fmt = 1'b0;
    wt(6);
    cmp(lit, 1'b0);
    step = 1'b1;
    wt(2);
    step = 1'b0;
    wt(6);
    cmp(lit, 1'b0);
    $display("Format done");
  endtask : t_format
  initial
  begin
    wt(2);
    cmp(lit, 1'b0);
    sys_rst = 1'b0;
    t_steady();
    t_blink();
    t_format();
    stop_test();
  end
endmodule : tb_top
